//--- spt_params.svh
`ifndef SPT_PARAMS_SVH
`define SPT_PARAMS_SVH
// Summary of operation
// R1 - class 0 for miss and block-load reads, class 1 for everything else
// R2 - interconnect keeps order inside a class; classes are independent
// R3 - each outgoing request carries a four-bit transaction-type field
// R4 - load miss sends shared read; instruction-fetch miss sends always-shared read
// R5 - store miss, store hit on shared line, rmw merge send read-to-own
// R6 - block loads send read-to-discard
// R7 - dirty victim sends writeback tied to earlier coherent read
// R8 - block store sends write-and-invalidate
// R9 - interrupt request delivers a 64-byte packet
// R10 - noncached read moves 1 to 16 bytes; 64-byte blocks use block requests
// R11 - copyback-discard keeps line state and skips store-buffer tag flush
// R12 - only slave read is forwarded noncached read; answer port id, read-ack-single
// R13 - system puts interrupt packet on data bus and tells buffer to accept
// R14 - five output wires carry reply, idle code 00000 when quiet
// R15 - non-existent-block reply when block absent, only without duplicate tags
// R16 - snoop: plain ack when present, dirty-victim ack when pending writeback
// R17 - interrupt-ack 1100 after servicing, room for one more interrupt
// R18 - noncached block read gets read-error and no data
// R19 - address or tag parity error sends fatal-error reply
// R20 - codes: fatal 0100, read error 0101, non-existent 0111
// R21 - codes: read-ack-single 1000, coherent ack 1010, dirty-victim ack 1101
// R22 - idle and fatal last one cycle, others two; class rules per reply
// R23 - system codes: slave read 1110, read ack 1010, interrupt block 1101
// R24 - multi-cycle reply held stable on every one of its cycles

// widths
`define SPT_ADDR_W      38
`define SPT_TYPE_W      4
`define SPT_SIZE_W      3

// classes
`define SPT_CLASS_READ  1'h0
`define SPT_CLASS_WRITE 1'h1

// outgoing transaction types
`define SPT_T_RDS       4'h0
`define SPT_T_RDSA      4'h1
`define SPT_T_RDO       4'h2
`define SPT_T_RDD       4'h3
`define SPT_T_WRB       4'h4
`define SPT_T_WRI       4'h5
`define SPT_T_INT       4'h6
`define SPT_T_NCRD      4'h7
`define SPT_T_NCBRD     4'h8
`define SPT_T_NCBWR     4'h9

// incoming transaction types
`define SPT_S_INV       4'h0
`define SPT_S_CPB       4'h1
`define SPT_S_CPI       4'h2
`define SPT_S_CPD       4'h3
`define SPT_S_NCRD      4'h7
`define SPT_S_NCBRD     4'h8
`define SPT_S_INT       4'h6

// transfer size codes, log2 of bytes
`define SPT_SIZE_MAX_NC 3'h4
`define SPT_SIZE_BLOCK  3'h6

// reply codes
`define SPT_R_IDLE      5'h00
`define SPT_R_FERR      4'h4
`define SPT_R_RERR      4'h5
`define SPT_R_SNACK     4'h7
`define SPT_R_RAS       4'h8
`define SPT_R_SACK      4'ha
`define SPT_R_IAK       4'hc
`define SPT_R_SACKD     4'hd

// system reply codes seen in the slave flows
`define SPT_SR_SRS      4'he
`define SPT_SR_RAS      4'ha
`define SPT_SR_SWIB     4'hd
`endif

//--- spt_pkg.sv
package spt_pkg;
`include "spt_params.svh"

  typedef enum logic [3:0] {
    SPT_OP_LOAD_MISS,
    SPT_OP_IFETCH_MISS,
    SPT_OP_STORE_MISS,
    SPT_OP_STORE_HIT_SHARED,
    SPT_OP_RMW_MERGE,
    SPT_OP_BLOCK_LOAD,
    SPT_OP_WRITEBACK,
    SPT_OP_BLOCK_STORE,
    SPT_OP_INTERRUPT,
    SPT_OP_NC_READ,
    SPT_OP_NC_BLOCK_READ,
    SPT_OP_NC_BLOCK_WRITE
  } spt_core_op_type;

  typedef struct packed {
    logic                   valid;
    spt_core_op_type        op;
    logic [`SPT_ADDR_W-1:0] addr;
    logic [`SPT_SIZE_W-1:0] size;
  } spt_core_req_type;

  typedef struct packed {
    logic                   valid;
    logic                   cls;
    logic [`SPT_TYPE_W-1:0] ttype;
    logic [`SPT_ADDR_W-1:0] addr;
    logic [`SPT_SIZE_W-1:0] size;
  } spt_pkt_type;

  typedef struct packed {
    logic                   valid;
    logic                   cls;
    logic [`SPT_TYPE_W-1:0] ttype;
    logic [`SPT_ADDR_W-1:0] addr;
    logic                   parity;
  } spt_sys_req_type;

  typedef struct packed {
    logic                   valid;
    logic                   invalidate;
    logic                   copyback;
    logic                   keep_state;
    logic                   flush_sb_check;
    logic [`SPT_ADDR_W-1:0] addr;
  } spt_snoop_type;

  typedef struct packed {
    logic                   cls;
    logic [`SPT_TYPE_W-1:0] code;
  } spt_reply_type;

  typedef enum logic [1:0] {
    SPT_RPL_IDLE,
    SPT_RPL_SECOND
  } spt_rpl_state_type;

  typedef struct packed {
    spt_sys_req_type   in_meta;
    spt_sys_req_type   in_sync;
    logic              gnt_meta;
    logic              gnt_sync;
    logic              dtag_meta;
    logic              dtag_sync;
    spt_pkt_type       pkt;
    spt_snoop_type     snoop;
    logic              pid_load;
    logic              int_arrive;
    logic              int_pend;
    logic              int_cls;
    logic              iak_pend;
    logic              iak_cls;
    logic              ferr_pend;
    logic              rpl_pend;
    spt_reply_type     rpl_next;
    spt_reply_type     reply;
    spt_rpl_state_type rpl_state;
  } spt_state_type;
endpackage

//--- spt_sys_model.sv
`timescale 1ns/1ns
`include "spt_params.svh"
module spt_sys_model
  import spt_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire spt_pkt_type system_address_bus_o,
  input  wire logic [3:0]  grant_delay_i,
  input  wire spt_reply_type p_reply_i,
  output logic [3:0]       s_reply_o,
  output logic             sys_grant_o,
  output spt_sys_req_type  sys_req_o
);
  logic [3:0] wait_cnt;
  logic [2:0] cool_cnt;
  initial begin
    sys_grant_o = 1'b0;
    s_reply_o = 4'h0;
    sys_req_o = '0;
    wait_cnt = '0;
    cool_cnt = '0;
  end
  ////////////////////////////////////////
  // one grant pulse per packet, in issue order; cool-down avoids eating the next one
  always @(posedge core_clk_i) begin
    #1;
    if (cool_cnt != 3'h0) begin
      cool_cnt = cool_cnt - 3'h1;
    end else if (sys_grant_o) begin
      sys_grant_o = 1'b0;
      cool_cnt = 3'h4;
    end else if (system_address_bus_o.valid) begin
      if (wait_cnt >= grant_delay_i) begin
        sys_grant_o = 1'b1;
        wait_cnt = '0;
      end else begin
        wait_cnt = wait_cnt + 4'h1;
      end
    end
  end
  // slave read flow: a single read ack from the port is answered by slave-read-single
  always @(posedge core_clk_i) begin
    #1;
    s_reply_o = (p_reply_i.code == `SPT_R_RAS) ? `SPT_SR_SRS : 4'h0;
  end
  // one-cycle packet; afterwards the released lines show the inverse
  task automatic send(input logic [3:0] tt, input logic cls, input logic bad_par);
    @(posedge core_clk_i);
    #1;
    sys_req_o.valid = 1'b1;
    sys_req_o.cls = cls;
    sys_req_o.ttype = tt;
    sys_req_o.addr = 38'h12_3456_7890;
    sys_req_o.parity = (^sys_req_o.addr) ^ bad_par;
    @(posedge core_clk_i);
    #1;
    sys_req_o = ~sys_req_o;
    sys_req_o.valid = 1'b0;
  endtask
endmodule

//--- spt_system_port.sv
`timescale 1ns/1ns
`include "spt_params.svh"
module spt_system_port
  import spt_pkg::*;
#(
  parameter logic [7:0] PORT_ID = 8'h00  // arbitrary value, set per board
) (
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  // request side from the cache controller
  input  wire spt_core_req_type core_req_i,
  output logic                  core_req_ready_o,
  // outgoing packet on the system address bus
  output spt_pkt_type           system_address_bus_o,
  input  wire logic             sys_grant_i,
  // incoming packet from the system controller
  input  wire spt_sys_req_type  system_address_bus_i,
  // strap: duplicate tags fitted in the system
  input  wire logic             duplicate_tags_i,
  // cache lookup for the snoop in flight
  input  wire logic             line_present_i,
  input  wire logic             victim_pending_i,
  input  wire logic             tag_parity_err_i,
  input  wire logic             int_serviced_i,
  // snoop command to the cache controller
  output spt_snoop_type         snoop_o,
  // port id to the data buffer
  output logic [7:0]            port_id_o,
  output logic                  port_id_load_o,
  output logic                  int_arrive_o,
  // five reply wires to the system
  output spt_reply_type         p_reply_o
);

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_q;
  logic rst_n_q;

  // async assert, release after two edges
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request classification

  // reads that fill the cache travel apart from writes
  function automatic logic op_class(input spt_core_op_type op);
    logic c;
    c = `SPT_CLASS_WRITE;
    unique case (op)
      SPT_OP_LOAD_MISS,
      SPT_OP_IFETCH_MISS,
      SPT_OP_STORE_MISS,
      SPT_OP_STORE_HIT_SHARED,
      SPT_OP_RMW_MERGE,
      SPT_OP_BLOCK_LOAD:     c = `SPT_CLASS_READ; // R1
      default:               c = `SPT_CLASS_WRITE; // R1
    endcase
    return c;
  endfunction

  // four-bit type field per core event
  function automatic logic [`SPT_TYPE_W-1:0] op_code(input spt_core_op_type op);
    logic [`SPT_TYPE_W-1:0] t;
    t = `SPT_T_NCRD;
    unique case (op)
      SPT_OP_LOAD_MISS:        t = `SPT_T_RDS;   // R4
      SPT_OP_IFETCH_MISS:      t = `SPT_T_RDSA;  // R4
      SPT_OP_STORE_MISS,
      SPT_OP_STORE_HIT_SHARED,
      SPT_OP_RMW_MERGE:        t = `SPT_T_RDO;   // R5
      SPT_OP_BLOCK_LOAD:       t = `SPT_T_RDD;   // R6
      SPT_OP_WRITEBACK:        t = `SPT_T_WRB;   // R7
      SPT_OP_BLOCK_STORE:      t = `SPT_T_WRI;   // R8
      SPT_OP_INTERRUPT:        t = `SPT_T_INT;   // R9
      SPT_OP_NC_READ:          t = `SPT_T_NCRD;  // R10
      SPT_OP_NC_BLOCK_READ:    t = `SPT_T_NCBRD; // R10
      SPT_OP_NC_BLOCK_WRITE:   t = `SPT_T_NCBWR; // R10
      default:                 t = `SPT_T_NCRD;
    endcase
    return t;
  endfunction

  // only single noncached reads carry a short size
  function automatic logic [`SPT_SIZE_W-1:0] op_size(input spt_core_req_type r);
    logic [`SPT_SIZE_W-1:0] s;
    s = `SPT_SIZE_BLOCK;
    if (r.op == SPT_OP_NC_READ) begin
      // oversize asks are clipped to the 16-byte ceiling
      s = (r.size > `SPT_SIZE_MAX_NC) ? `SPT_SIZE_MAX_NC : r.size; // R10
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  spt_state_type st_q;
  spt_state_type st_d;
  spt_sys_req_type in_req;
  logic            addr_perr;
  logic            pkt_taken;
  logic            take_core;
  spt_reply_type   snoop_rpl;

  assign in_req    = st_q.in_sync;
  // even parity over address and check bit
  assign addr_perr = in_req.valid & (^{in_req.addr, in_req.parity}); // R19
  assign pkt_taken = st_q.pkt.valid & st_q.gnt_sync;
  // ordering in a class is kept by issuing one packet at a time
  assign take_core = core_req_i.valid & (~st_q.pkt.valid | pkt_taken); // R2

  // snoop reply from the lookup of this cycle
  always_comb begin
    snoop_rpl.cls = in_req.cls; // R22
    if (!line_present_i && !st_q.dtag_sync) begin
      snoop_rpl.code = `SPT_R_SNACK; // R15
    end else if (victim_pending_i) begin
      snoop_rpl.code = `SPT_R_SACKD; // R16
    end else begin
      snoop_rpl.code = `SPT_R_SACK; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;

    // pin inputs through two flops
    st_d.in_meta   = system_address_bus_i;
    st_d.in_sync   = st_q.in_meta;
    st_d.gnt_meta  = sys_grant_i;
    st_d.gnt_sync  = st_q.gnt_meta;
    st_d.dtag_meta = duplicate_tags_i;
    st_d.dtag_sync = st_q.dtag_meta;

    // single-cycle strobes
    st_d.snoop.valid = 1'b0;
    st_d.pid_load    = 1'b0;
    st_d.int_arrive  = 1'b0;

    // outgoing packet, held until granted
    if (pkt_taken) begin
      st_d.pkt.valid = 1'b0;
    end
    if (take_core) begin
      st_d.pkt.valid = 1'b1;
      st_d.pkt.cls   = op_class(core_req_i.op); // R1
      st_d.pkt.ttype = op_code(core_req_i.op);  // R3
      st_d.pkt.addr  = core_req_i.addr;
      st_d.pkt.size  = op_size(core_req_i);     // R9
    end

    // reply sequencer: clears first so later sets win
    unique case (st_q.rpl_state)
      SPT_RPL_IDLE: begin
        st_d.reply = `SPT_R_IDLE; // R14
        if (st_q.ferr_pend) begin
          st_d.reply.cls  = 1'b0;
          st_d.reply.code = `SPT_R_FERR; // R20
          st_d.ferr_pend  = 1'b0;
        end else if (st_q.rpl_pend) begin
          st_d.reply     = st_q.rpl_next;
          st_d.rpl_pend  = 1'b0;
          st_d.rpl_state = SPT_RPL_SECOND; // R22
        end else if (st_q.iak_pend) begin
          st_d.reply.cls  = st_q.iak_cls;
          st_d.reply.code = `SPT_R_IAK; // R17
          st_d.iak_pend   = 1'b0;
          st_d.rpl_state  = SPT_RPL_SECOND;
        end
      end
      SPT_RPL_SECOND: begin
        // same code again, fatal waits for the end
        st_d.reply     = st_q.reply; // R24
        st_d.rpl_state = SPT_RPL_IDLE;
      end
    endcase

    // parity faults from the bus or the tags
    if (addr_perr || tag_parity_err_i) begin
      st_d.ferr_pend = 1'b1; // R19
    end

    // decode of a clean incoming packet
    if (in_req.valid && !addr_perr) begin
      unique case (in_req.ttype)
        `SPT_S_INV: begin
          st_d.snoop.valid          = 1'b1;
          st_d.snoop.invalidate     = 1'b1;
          st_d.snoop.copyback       = 1'b0;
          st_d.snoop.keep_state     = 1'b0;
          st_d.snoop.flush_sb_check = 1'b1;
          st_d.snoop.addr           = in_req.addr;
          st_d.rpl_pend             = 1'b1;
          st_d.rpl_next             = snoop_rpl; // R16
        end
        `SPT_S_CPB,
        `SPT_S_CPI: begin
          st_d.snoop.valid          = 1'b1;
          st_d.snoop.invalidate     = (in_req.ttype == `SPT_S_CPI);
          st_d.snoop.copyback       = 1'b1;
          st_d.snoop.keep_state     = 1'b0;
          st_d.snoop.flush_sb_check = 1'b1;
          st_d.snoop.addr           = in_req.addr;
          st_d.rpl_pend             = 1'b1;
          st_d.rpl_next             = snoop_rpl; // R16
        end
        `SPT_S_CPD: begin
          // discarding reader: the line keeps its state
          st_d.snoop.valid          = 1'b1;
          st_d.snoop.invalidate     = 1'b0;
          st_d.snoop.copyback       = 1'b1;
          st_d.snoop.keep_state     = 1'b1; // R11
          st_d.snoop.flush_sb_check = 1'b0; // R11
          st_d.snoop.addr           = in_req.addr;
          st_d.rpl_pend             = 1'b1;
          st_d.rpl_next             = snoop_rpl; // R16
        end
        `SPT_S_NCRD: begin
          // the one slave read: hand over the port id
          st_d.pid_load      = 1'b1; // R12
          st_d.rpl_pend      = 1'b1;
          st_d.rpl_next.cls  = in_req.cls;
          st_d.rpl_next.code = `SPT_R_RAS; // R21
        end
        `SPT_S_NCBRD: begin
          // no data moves on a block read of the port
          st_d.rpl_pend      = 1'b1;
          st_d.rpl_next.cls  = in_req.cls;
          st_d.rpl_next.code = `SPT_R_RERR; // R18
        end
        `SPT_S_INT: begin
          // packet data lands in the buffer alongside
          st_d.int_arrive = 1'b1; // R13
          st_d.int_pend   = 1'b1;
          st_d.int_cls    = in_req.cls;
        end
        default: begin
          // cacheable reads of the port are left unanswered
          st_d.rpl_pend = st_d.rpl_pend;
        end
      endcase
    end

    // servicing done: one more interrupt fits
    if (int_serviced_i && st_q.int_pend) begin
      st_d.iak_pend = 1'b1; // R17
      st_d.iak_cls  = st_q.int_cls;
      if (!(in_req.valid && !addr_perr && in_req.ttype == `SPT_S_INT)) begin
        st_d.int_pend = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign core_req_ready_o     = ~st_q.pkt.valid | pkt_taken;
  assign system_address_bus_o = st_q.pkt;
  assign snoop_o              = st_q.snoop;
  assign port_id_o            = PORT_ID;
  assign port_id_load_o       = st_q.pid_load;
  assign int_arrive_o         = st_q.int_arrive;
  assign p_reply_o            = st_q.reply; // R14

endmodule

//--- spt_system_port_properties.sv
`timescale 1ns/1ns
`include "spt_params.svh"
module spt_system_port_properties
  import spt_pkg::*;
#(
  parameter logic [7:0] PORT_ID = 8'h00
) (
  input wire logic             core_clk_i,
  input wire logic             resetn_i,
  input wire spt_core_req_type core_req_i,
  input wire logic             core_req_ready_o,
  input wire spt_pkt_type      system_address_bus_o,
  input wire logic             sys_grant_i,
  input wire spt_sys_req_type  system_address_bus_i,
  input wire logic             duplicate_tags_i,
  input wire logic             line_present_i,
  input wire logic             victim_pending_i,
  input wire logic             tag_parity_err_i,
  input wire logic             int_serviced_i,
  input wire spt_snoop_type    snoop_o,
  input wire logic [7:0]       port_id_o,
  input wire logic             port_id_load_o,
  input wire logic             int_arrive_o,
  input wire spt_reply_type    p_reply_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////
  // a reply opening after idle or fatal; chained replies are not judged here
  sequence s_reply_open;
    p_reply_o.code != 4'h0 && p_reply_o.code != `SPT_R_FERR &&
      ($past(p_reply_o.code) == 4'h0 || $past(p_reply_o.code) == `SPT_R_FERR);
  endsequence
  sequence s_bad_parity;
    system_address_bus_i.valid && (^{system_address_bus_i.addr, system_address_bus_i.parity});
  endsequence
  chk_reply_held: assert property (s_reply_open |=> $stable(p_reply_o))
    else $error("two-cycle reply not held");
  chk_fatal_one: assert property (p_reply_o.code == `SPT_R_FERR |=> p_reply_o.code != `SPT_R_FERR)
    else $error("fatal reply longer than one cycle");
  chk_idle_class: assert property (p_reply_o.code == 4'h0 |-> p_reply_o.cls == 1'b0)
    else $error("idle reply with class set");
  chk_code_legal: assert property (p_reply_o.code inside {4'h0, `SPT_R_FERR, `SPT_R_RERR,
    `SPT_R_SNACK, `SPT_R_RAS, `SPT_R_SACK, `SPT_R_IAK, `SPT_R_SACKD})
    else $error("undefined reply code");
  chk_parity_fatal: assert property (s_bad_parity |-> ##[2:8] p_reply_o.code == `SPT_R_FERR)
    else $error("no fatal reply after address parity error");
  chk_tag_fatal: assert property (tag_parity_err_i |-> ##[1:8] p_reply_o.code == `SPT_R_FERR)
    else $error("no fatal reply after tag parity error");
  chk_snoop_reply: assert property (snoop_o.valid |-> ##[1:4]
    p_reply_o.code inside {`SPT_R_SNACK, `SPT_R_SACK, `SPT_R_SACKD})
    else $error("snoop without coherent reply");
  chk_copyback_keep: assert property (snoop_o.valid && snoop_o.keep_state
    |-> !snoop_o.flush_sb_check && !snoop_o.invalidate)
    else $error("discard copyback touches line state");
  chk_pid_ras: assert property (port_id_load_o |-> ##[1:4] p_reply_o.code == `SPT_R_RAS)
    else $error("port id load without single read ack");
  chk_pkt_hold: assert property (system_address_bus_o.valid && !core_req_ready_o
    |=> $stable(system_address_bus_o))
    else $error("ungranted packet changed");
  chk_port_id: assert property (port_id_o == PORT_ID)
    else $error("port id differs from parameter");
endmodule

bind spt_system_port spt_system_port_properties #(.PORT_ID(PORT_ID)) chk_i (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .core_req_i(core_req_i),
  .core_req_ready_o(core_req_ready_o), .system_address_bus_o(system_address_bus_o),
  .sys_grant_i(sys_grant_i), .system_address_bus_i(system_address_bus_i),
  .duplicate_tags_i(duplicate_tags_i), .line_present_i(line_present_i),
  .victim_pending_i(victim_pending_i), .tag_parity_err_i(tag_parity_err_i),
  .int_serviced_i(int_serviced_i), .snoop_o(snoop_o), .port_id_o(port_id_o),
  .port_id_load_o(port_id_load_o), .int_arrive_o(int_arrive_o), .p_reply_o(p_reply_o));

//--- tb_spt_system_port.sv
`timescale 1ns/1ns
`include "spt_params.svh"
module tb_spt_system_port
  import spt_pkg::*;
;
  localparam logic [7:0]  PID = 8'h3c;  // arbitrary value
  localparam logic [11:0] CLS = 12'hfc0;
  logic [3:0] exp_tt [12] = '{`SPT_T_RDS, `SPT_T_RDSA, `SPT_T_RDO, `SPT_T_RDO, `SPT_T_RDO,
    `SPT_T_RDD, `SPT_T_WRB, `SPT_T_WRI, `SPT_T_INT, `SPT_T_NCRD, `SPT_T_NCBRD, `SPT_T_NCBWR};
  logic             core_clk_i = 1'b0;
  logic             resetn_i = 1'b0;
  spt_core_req_type core_req = '0;
  logic             ready, grant, pid_load, int_arrive;
  logic             dup_tags = 1'b0, present = 1'b0, victim = 1'b0;
  logic             tag_err = 1'b0, serviced = 1'b0;
  logic [3:0]       gdelay = 4'h0;
  spt_pkt_type      bus_o;
  spt_sys_req_type  bus_i;
  spt_snoop_type    snoop, snoop_seen;
  logic [7:0]       pid;
  spt_reply_type    reply;
  int               failures = 0, cmp_count = 0, pid_cnt = 0, int_cnt = 0;
  int               srs_cnt = 0;
  logic [3:0]       s_reply;
  ////////////////////////////////////////
  always #5 core_clk_i = ~core_clk_i;
  spt_system_port #(.PORT_ID(PID)) spt_system_port_i (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .core_req_i(core_req),
    .core_req_ready_o(ready), .system_address_bus_o(bus_o), .sys_grant_i(grant),
    .system_address_bus_i(bus_i), .duplicate_tags_i(dup_tags), .line_present_i(present),
    .victim_pending_i(victim), .tag_parity_err_i(tag_err), .int_serviced_i(serviced),
    .snoop_o(snoop), .port_id_o(pid), .port_id_load_o(pid_load),
    .int_arrive_o(int_arrive), .p_reply_o(reply));
  spt_sys_model spt_sys_model_i (.core_clk_i(core_clk_i), .system_address_bus_o(bus_o),
    .grant_delay_i(gdelay), .p_reply_i(reply), .s_reply_o(s_reply),
    .sys_grant_o(grant), .sys_req_o(bus_i));
  // strobes are one cycle wide, so count them as they pass
  always @(posedge core_clk_i) begin
    if (snoop.valid === 1'b1) snoop_seen <= snoop;
    if (pid_load === 1'b1) pid_cnt <= pid_cnt + 1;
    if (int_arrive === 1'b1) int_cnt <= int_cnt + 1;
    if (s_reply === `SPT_SR_SRS) srs_cnt <= srs_cnt + 1;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick;
    @(posedge core_clk_i);
    #1;
  endtask
  // waits for a reply to open, checks each of its cycles, then idle
  task automatic expect_reply(input logic [3:0] code, input logic cls, input int n);
    int i;
    i = 0;
    while (reply.code === 4'h0 && i < 20) begin
      tick();
      i++;
    end
    for (int k = 0; k < n; k++) begin
      chk("reply", {3'h0, cls, code}, {3'h0, reply});
      tick();
    end
    chk("reply_idle", 8'h00, {3'h0, reply});
  endtask
  task automatic issue(input int op);
    int i;
    core_req = '{valid: 1'b1, op: spt_core_op_type'(op), addr: 38'h10_0000_0040, size: 3'h5};
    i = 0;
    while (ready !== 1'b1 && i < 40) begin
      tick();
      i++;
    end
    tick();
    core_req.valid = 1'b0;
    chk("ready_busy", 8'h00, {7'h0, ready});
    chk("pkt_valid", 8'h01, {7'h0, bus_o.valid});
    chk("pkt_ttype", {4'h0, exp_tt[op]}, {4'h0, bus_o.ttype});
    chk("pkt_class", {7'h0, CLS[op]}, {7'h0, bus_o.cls});
    chk("pkt_size", (op == 9) ? 8'h04 : 8'h06, {5'h0, bus_o.size});
    chk("pkt_addr", 8'h40, bus_o.addr[7:0]);
  endtask
  task automatic t_in(input logic [3:0] tt, input logic cls, input logic [2:0] lk,
                      input logic [3:0] code);
    {dup_tags, present, victim} = lk;
    repeat (3) tick();
    spt_sys_model_i.send(tt, cls, 1'b0);
    expect_reply(code, cls, 2);
  endtask
  ////////////////////////////////////////
  task automatic t_out;
    for (int d = 0; d < 2; d++) begin
      gdelay = d[0] ? 4'h5 : 4'h0;
      for (int op = 0; op < 12; op++) issue(op);
    end
    repeat (12) tick();
    $display("test outgoing done");
  endtask
  task automatic t_snoop;
    t_in(`SPT_S_INV, 1'b0, 3'b010, `SPT_R_SACK);
    t_in(`SPT_S_CPB, 1'b1, 3'b011, `SPT_R_SACKD);
    t_in(`SPT_S_CPI, 1'b1, 3'b000, `SPT_R_SNACK);
    chk("cpi_invalidate", 8'h01, {7'h0, snoop_seen.invalidate});
    chk("cpi_copyback", 8'h01, {7'h0, snoop_seen.copyback});
    chk("snoop_addr", 8'h90, snoop_seen.addr[7:0]);
    t_in(`SPT_S_CPD, 1'b0, 3'b100, `SPT_R_SACK);
    chk("keep_state", 8'h01, {7'h0, snoop_seen.keep_state});
    chk("flush_check", 8'h00, {7'h0, snoop_seen.flush_sb_check});
    $display("test snoop done");
  endtask
  task automatic t_slave;
    t_in(`SPT_S_NCRD, 1'b1, 3'b000, `SPT_R_RAS);
    chk("pid_loads", 8'h01, pid_cnt[7:0]);
    chk("port_id", PID, pid);
    chk("srs_cycles", 8'h02, srs_cnt[7:0]);
    t_in(`SPT_S_NCBRD, 1'b0, 3'b000, `SPT_R_RERR);
    chk("pid_no_data", 8'h01, pid_cnt[7:0]);
    $display("test slave done");
  endtask
  task automatic t_int;
    spt_sys_model_i.send(`SPT_S_INT, 1'b1, 1'b0);
    repeat (8) tick();
    chk("int_arrive", 8'h01, int_cnt[7:0]);
    chk("no_early_ack", 8'h00, {3'h0, reply});
    serviced = 1'b1;
    tick();
    serviced = 1'b0;
    expect_reply(`SPT_R_IAK, 1'b1, 2);
    $display("test interrupt done");
  endtask
  task automatic t_fatal;
    spt_sys_model_i.send(`SPT_S_NCRD, 1'b1, 1'b1);
    expect_reply(`SPT_R_FERR, 1'b0, 1);
    chk("bad_pkt_ignored", 8'h01, pid_cnt[7:0]);
    tag_err = 1'b1;
    tick();
    tag_err = 1'b0;
    expect_reply(`SPT_R_FERR, 1'b0, 1);
    $display("test fatal done");
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk_i);
    #1;
    resetn_i = 1'b1;
    repeat (3) tick();
    t_out();
    t_snoop();
    t_slave();
    t_int();
    t_fatal();
    close_out();
  end
  // the whole run needs well under 2000 cycles
  initial begin
    #200000;
    failures++;
    $display("watchdog expired");
    close_out();
  end
endmodule
